// ---- wbl_pkg.sv ----
/*
 * Shared constants for the work bit logic unit: register map, field
 * layouts, operation codes, selector codes and timing.
 * Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
 */
package wbl_pkg;

    // ==========================================================
    // Sizes and timing
    // ==========================================================
    localparam int          WBL_NUM_BITS     = 8;
    localparam int          WBL_SEL_W        = 6;
    localparam int          WBL_DLY_W        = 14;
    localparam logic [13:0] WBL_DLY_MAX      = 14'h270f;
    localparam int          WBL_CLK_HZ       = 100000000;
    localparam int          WBL_SEC_S        = 1;
    localparam int          WBL_MIN_S        = 60;
    localparam int          WBL_SEC_CYCLES   = WBL_CLK_HZ * WBL_SEC_S;
    localparam int          WBL_SEC_PER_MIN  = WBL_MIN_S / WBL_SEC_S;

    // ==========================================================
    // Operation types
    // ==========================================================
    typedef enum logic [2:0] {
        WBL_OP_OFF = 3'b000,
        WBL_OP_1   = 3'b001,
        WBL_OP_2   = 3'b010,
        WBL_OP_3   = 3'b011,
        WBL_OP_4   = 3'b100
    } wbl_op_e;

    // ==========================================================
    // Condition selector codes
    // ==========================================================
    localparam logic [5:0] WBL_SEL_OFF      = 6'h00;
    localparam logic [5:0] WBL_SEL_ON       = 6'h01;
    localparam logic [5:0] WBL_SEL_PWRON    = 6'h02;
    localparam logic [5:0] WBL_SEL_EV_BASE  = 6'h03;  // Event inputs 3..8
    localparam logic [5:0] WBL_SEL_ST_BASE  = 6'h09;  // Status 9..28
    localparam logic [5:0] WBL_SEL_WB_BASE  = 6'h1d;  // Work bits 29..36
    localparam logic [5:0] WBL_SEL_AD_BASE  = 6'h25;  // Status 37..40
    localparam logic [5:0] WBL_SEL_MAX      = 6'h28;
    localparam int         WBL_NUM_EV       = 6;
    localparam int         WBL_NUM_ST       = 24;

    // ==========================================================
    // Register map, per work bit n: base + n*stride
    // ==========================================================
    localparam logic [7:0] WBL_REG_CFG_BASE = 8'h00;  // Op, inversions, unit
    localparam logic [7:0] WBL_REG_SEL_BASE = 8'h04;  // Selectors A..D
    localparam logic [7:0] WBL_REG_DLY_BASE = 8'h08;  // ON / OFF delay
    localparam int         WBL_REG_STRIDE   = 16;
    localparam logic [7:0] WBL_REG_STATUS   = 8'h80;  // Results, raw, in use

    // CFG fields
    localparam int WBL_CFG_OP_LSB   = 0;
    localparam int WBL_CFG_INV_LSB  = 4;   // Bits 4..7 invert A..D
    localparam int WBL_CFG_OINV_BIT = 8;   // Invert result
    localparam int WBL_CFG_UNIT_BIT = 9;   // 0 seconds, 1 minutes
    // SEL fields, 8 bits per condition
    localparam int WBL_SEL_STRIDE   = 8;
    // DLY fields
    localparam int WBL_DLY_ON_LSB   = 0;
    localparam int WBL_DLY_OFF_LSB  = 16;

    localparam logic [31:0] WBL_RD_UNMAPPED = 32'h0000_0000;

endpackage : wbl_pkg

// ---- wbl_delay.sv ----
/*
 * One work bit output timer: ON and OFF delays counted in ticks.
 * Assumes the tick enable is a one-cycle pulse in the core clock domain.
 */
`timescale 1ns/10ps
module wbl_delay
    import wbl_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 tick_i,
    input  wire logic                 raw_i,
    input  wire logic [WBL_DLY_W-1:0] on_dly_i,
    input  wire logic [WBL_DLY_W-1:0] off_dly_i,
    output logic                      out_o
);

    logic                 out_q;
    logic                 next_out;
    logic [WBL_DLY_W-1:0] cnt;
    logic [WBL_DLY_W-1:0] next_cnt;
    logic [WBL_DLY_W-1:0] target;

    // ==========================================================
    // Delay state update
    // ==========================================================
    always_comb begin
        next_out = out_q;
        next_cnt = cnt;
        target   = raw_i ? on_dly_i : off_dly_i;
        if (raw_i == out_q) begin
            // restart on change: a pending edge is cancelled
            next_cnt = '0;
        end else if (target == '0) begin
            next_out = raw_i;
            next_cnt = '0;
        end else if (tick_i) begin
            if (cnt + 14'h0001 >= target) begin
                next_out = raw_i;
                next_cnt = '0;
            end else begin
                next_cnt = cnt + 14'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            out_q <= 1'b0;
            cnt   <= '0;
        end else begin
            out_q <= next_out;
            cnt   <= next_cnt;
        end
    end

    assign out_o = out_q;

endmodule : wbl_delay

// ---- wbl_unit.sv ----
/*
 * Work bit logic unit: eight configurable result bits, each combining
 * four selected conditions, with optional inversion and ON/OFF delay,
 * configured over an Avalon-MM slave.
 * Assumes status and event inputs are synchronous to core_clk_i.
 */
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
// Overview of operation
// - Each result is one binary value
// - Eight independently configured result bits
// - Reset sets every bit to off
// - Four combining patterns plus off
// - Type 1: (A and B) or (C and D)
// - Type 2: (A or C) and (B or D)
// - Type 3: any condition true
// - Type 4: all four conditions true
// - Results exported for outputs and modes
// - Display dot while any bit active
// - Selector 0..40 picks each condition
// - Optional inversion of inputs and result
// - ON delay 0..9999, zero means none
// - OFF delay 0..9999, seconds or minutes
`timescale 1ns/10ps
module wbl_unit
    import wbl_pkg::*;
#(
    parameter int SEC_CYCLES = WBL_SEC_CYCLES
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_n_i,
    // Avalon-MM slave
    input  wire logic [7:0]              avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic [31:0]                  avs_readdata_o,
    output logic                         avs_waitrequest_o,
    // Sources
    input  wire logic [WBL_NUM_EV-1:0]   event_in_i,
    input  wire logic [WBL_NUM_ST-1:0]   status_in_i,
    // Results
    output logic [WBL_NUM_BITS-1:0]      work_bit_o,
    output logic                         adj_dot_o
);

    // ==========================================================
    // Configuration storage
    // ==========================================================
    // Flops per work bit, indexed by bit number; the next_ arrays
    // are rebuilt every cycle so unwritten words simply hold
    logic [31:0] cfg_reg [WBL_NUM_BITS];
    logic [31:0] sel_reg [WBL_NUM_BITS];
    logic [31:0] dly_reg [WBL_NUM_BITS];
    logic [31:0] next_cfg [WBL_NUM_BITS];
    logic [31:0] next_sel [WBL_NUM_BITS];
    logic [31:0] next_dly [WBL_NUM_BITS];
    logic        ack;
    logic        next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [31:0] status_word;
    logic        pwr_pulse;
    logic        next_pwr_pulse;
    logic [31:0] sec_cnt;
    logic [31:0] next_sec_cnt;
    logic [5:0]  min_cnt;
    logic [5:0]  next_min_cnt;
    logic        sec_tick;
    logic        min_tick;
    logic [WBL_NUM_BITS-1:0] raw;
    logic [WBL_NUM_BITS-1:0] delayed;
    logic [WBL_NUM_BITS-1:0] active;

    // Merge write data under byte enables
    // Lanes without their enable keep the old byte
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_be

    // Clamp a written delay to the legal range
    // Values above the maximum are kept at the maximum, never wrapped
    function automatic logic [15:0] clamp_dly(input logic [15:0] v);
        return (v > {2'b00, WBL_DLY_MAX}) ? {2'b00, WBL_DLY_MAX} : v;
    endfunction : clamp_dly

    // Address match for one register group of work bit n
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] base,
                                     input int         n);
        return addr == 8'(base + n * WBL_REG_STRIDE);
    endfunction : reg_hit

    // selector decode, codes above 40 read as off
    // Status bits 20..23 carry the codes above the work bit range
    function automatic logic pick(input logic [5:0]              code,
                                  input logic                    pwr,
                                  input logic [WBL_NUM_EV-1:0]   ev,
                                  input logic [WBL_NUM_ST-1:0]   st,
                                  input logic [WBL_NUM_BITS-1:0] wb);
        logic r;
        r = 1'b0;
        if (code == WBL_SEL_ON) begin
            r = 1'b1;
        end else if (code == WBL_SEL_PWRON) begin
            r = pwr;
        end else if (code >= WBL_SEL_EV_BASE && code < WBL_SEL_ST_BASE) begin
            r = ev[3'(code - WBL_SEL_EV_BASE)];
        end else if (code >= WBL_SEL_ST_BASE && code < WBL_SEL_WB_BASE) begin
            r = st[5'(code - WBL_SEL_ST_BASE)];
        end else if (code >= WBL_SEL_WB_BASE && code < WBL_SEL_AD_BASE) begin
            r = wb[3'(code - WBL_SEL_WB_BASE)];
        end else if (code >= WBL_SEL_AD_BASE && code <= WBL_SEL_MAX) begin
            r = st[5'(code - WBL_SEL_AD_BASE + 6'h14)];
        end
        return r;
    endfunction : pick

    // ==========================================================
    // Bus slave: one wait state, then answer
    // ==========================================================
    // Waitrequest drops the cycle after the request so reads come from flops.
    // Read data is captured in the first cycle of a request; a write lands
    // only at the edge where waitrequest is low, as the master expects.
    always_comb begin
        next_ack   = (avs_read_i || avs_write_i) && !ack;
        next_rdata = WBL_RD_UNMAPPED;
        for (int n = 0; n < WBL_NUM_BITS; n++) begin
            next_cfg[n] = cfg_reg[n];
            next_sel[n] = sel_reg[n];
            next_dly[n] = dly_reg[n];
        end
        if (avs_read_i || avs_write_i) begin
            for (int n = 0; n < WBL_NUM_BITS; n++) begin
                if (reg_hit(avs_address_i, WBL_REG_CFG_BASE, n)) begin
                    if (!ack) begin
                        next_rdata = cfg_reg[n];
                    end
                    if (avs_write_i && ack) begin
                        next_cfg[n] = merge_be(cfg_reg[n], avs_writedata_i, avs_byteenable_i) & 32'h0000_03f7;
                        // only five legal types, others fall back to off
                        if (next_cfg[n][2:0] > 3'(WBL_OP_4)) begin
                            next_cfg[n][2:0] = 3'(WBL_OP_OFF);
                        end
                    end
                end
                if (reg_hit(avs_address_i, WBL_REG_SEL_BASE, n)) begin
                    if (!ack) begin
                        next_rdata = sel_reg[n];
                    end
                    if (avs_write_i && ack) begin
                        next_sel[n] = merge_be(sel_reg[n], avs_writedata_i, avs_byteenable_i) & 32'h3f3f_3f3f;
                    end
                end
                if (reg_hit(avs_address_i, WBL_REG_DLY_BASE, n)) begin
                    if (!ack) begin
                        next_rdata = dly_reg[n];
                    end
                    if (avs_write_i && ack) begin
                        next_dly[n] = merge_be(dly_reg[n], avs_writedata_i, avs_byteenable_i);
                        next_dly[n] = {clamp_dly(next_dly[n][31:16]), clamp_dly(next_dly[n][15:0])};
                    end
                end
            end
            // Status is read only; a write to it is dropped
            if (avs_address_i == WBL_REG_STATUS && !ack) begin
                next_rdata = status_word;
            end
        end
    end

    // reset puts every bit at no-operation with zero delays
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
            for (int n = 0; n < WBL_NUM_BITS; n++) begin
                cfg_reg[n] <= 32'h0000_0000;
                sel_reg[n] <= 32'h0000_0000;
                dly_reg[n] <= 32'h0000_0000;
            end
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
            for (int n = 0; n < WBL_NUM_BITS; n++) begin
                cfg_reg[n] <= next_cfg[n];
                sel_reg[n] <= next_sel[n];
                dly_reg[n] <= next_dly[n];
            end
        end
    end

    // Waitrequest is combinational: high in the first cycle of a request,
    // low in the second, so every access costs exactly two cycles
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign avs_readdata_o    = rdata;

    // Status word: dot, raw results, delayed results
    assign status_word       = {15'h0000, adj_dot_o, raw, delayed};

    // ==========================================================
    // Power-on pulse and tick dividers
    // ==========================================================
    // The pulse is set by reset, so it stands through reset and the first
    // cycle after release only; later cycles never see it again.
    // Dividers run free and are shared by all eight timers: a delay of D
    // units may end up to one unit early, traded for a single divider
    // instead of one per timer.
    // one-cycle pulse after reset release, and the second/minute dividers
    always_comb begin
        next_pwr_pulse = 1'b0;
        sec_tick       = (sec_cnt == 32'(SEC_CYCLES - 1));
        next_sec_cnt   = sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
        min_tick       = sec_tick && (min_cnt == 6'(WBL_SEC_PER_MIN - 1));
        next_min_cnt   = min_cnt;
        if (sec_tick) begin
            next_min_cnt = min_tick ? 6'h00 : min_cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pwr_pulse <= 1'b1;
            sec_cnt   <= 32'h0000_0000;
            min_cnt   <= 6'h00;
        end else begin
            pwr_pulse <= next_pwr_pulse;
            sec_cnt   <= next_sec_cnt;
            min_cnt   <= next_min_cnt;
        end
    end

    // ==========================================================
    // Combination logic per work bit
    // ==========================================================
    // Work bit sources read the delayed results, never the raw ones, so a
    // bit that selects itself or another bit settles one edge later
    // instead of forming a combinational loop.
    // each bit forms one value from its own settings
    always_comb begin
        logic [3:0] c;
        logic       r;
        c = 4'h0;
        r = 1'b0;
        for (int n = 0; n < WBL_NUM_BITS; n++) begin
            for (int k = 0; k < 4; k++) begin
                c[k] = pick(sel_reg[n][WBL_SEL_STRIDE*k +: WBL_SEL_W], pwr_pulse,
                            event_in_i, status_in_i, delayed)
                       ^ cfg_reg[n][WBL_CFG_INV_LSB + k];
            end
            case (wbl_op_e'(cfg_reg[n][2:0]))
                WBL_OP_1: r = (c[0] & c[1]) | (c[2] & c[3]);
                WBL_OP_2: r = (c[0] | c[2]) & (c[1] | c[3]);
                WBL_OP_3: r = |c;
                WBL_OP_4: r = &c;
                default:  r = 1'b0;
            endcase
            active[n] = (cfg_reg[n][2:0] != 3'(WBL_OP_OFF));
            // result inversion; off type forces zero
            raw[n] = active[n] & (r ^ cfg_reg[n][WBL_CFG_OINV_BIT]);
        end
    end

    // ==========================================================
    // Output delay timers
    // ==========================================================
    // Each timer sees only its own settings; the unit bit picks the tick
    // that it counts, for the ON and the OFF delay alike
    genvar g;
    generate
        for (g = 0; g < WBL_NUM_BITS; g++) begin : g_dly
            // unit picks the second or minute tick
            wbl_delay u_dly (
                .core_clk_i (core_clk_i),
                .rst_n_i    (rst_n_i),
                .tick_i     (cfg_reg[g][WBL_CFG_UNIT_BIT] ? min_tick : sec_tick),
                .raw_i      (raw[g]),
                .on_dly_i   (dly_reg[g][WBL_DLY_ON_LSB +: WBL_DLY_W]),
                .off_dly_i  (dly_reg[g][WBL_DLY_OFF_LSB +: WBL_DLY_W]),
                .out_o      (delayed[g])
            );
        end
    endgenerate

    // Results leave from the timer flops, so routing logic sees clean levels
    // results exported for routing
    assign work_bit_o = delayed;
    // dot lit while any bit is in use
    assign adj_dot_o  = |active;

endmodule : wbl_unit

// ---- wbl_unit_monitor.sv ----
/*
 * Port checker for the work bit logic unit: bus handshake, read-back
 * and reset behaviour. Assumes only the top ports are visible.
 */
`timescale 1ns/10ps
module wbl_unit_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [7:0]  work_bit_o,
    input wire logic        adj_dot_o
);
    // ====================================
    // Helpers
    // ====================================
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Request and read-accept terms shared by the checks
    logic req;
    logic rd_ok;
    assign req   = avs_read_i | avs_write_i;
    assign rd_ok = avs_read_i & ~avs_waitrequest_o;

    // ====================================
    // Checks
    // ====================================
    wait_first_a: assert property ((req && !$past(req && avs_waitrequest_o)) |-> avs_waitrequest_o)
        else $error("waitrequest low in first request cycle");
    wait_second_a: assert property ((req && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("more than one wait state");
    idle_low_a: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest high while idle");
    reset_clear_a: assert property ($rose(rst_n_i) |-> (work_bit_o == 8'h00 && !adj_dot_o))
        else $error("outputs not clear after reset");
    unmapped_zero_a: assert property ((rd_ok && (avs_address_i[3:0] == 4'hc || avs_address_i > 8'h80))
        |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    cfg_reserved_a: assert property ((rd_ok && !avs_address_i[7] && avs_address_i[3:0] == 4'h0)
        |-> (avs_readdata_o[31:10] == 22'h0 && !avs_readdata_o[3]))
        else $error("config reserved bits set");
    dot_status_a: assert property ((rd_ok && avs_address_i == 8'h80)
        |-> (avs_readdata_o[16] == adj_dot_o && avs_readdata_o[31:17] == 15'h0))
        else $error("dot differs from status");
    rdata_hold_a: assert property (!req ##1 !req |-> $stable(avs_readdata_o))
        else $error("read data moved while idle");
endmodule : wbl_unit_monitor

bind wbl_unit wbl_unit_monitor mon_u (
    .core_clk_i       (core_clk_i),
    .rst_n_i          (rst_n_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .work_bit_o       (work_bit_o),
    .adj_dot_o        (adj_dot_o)
);

// ---- wbl_src_model.sv ----
/*
 * Model of the controller status and event sources feeding the unit.
 * Assumes the bench asks for levels; they appear one clock later.
 */
`timescale 1ns/10ps
module wbl_src_model
    import wbl_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [WBL_NUM_EV-1:0] ev_req_i,
    input  wire logic [WBL_NUM_ST-1:0] st_req_i,
    output logic [WBL_NUM_EV-1:0]      event_o,
    output logic [WBL_NUM_ST-1:0]      status_o
);
    // ====================================
    // Source levels
    // ====================================
    logic [WBL_NUM_EV-1:0] next_event;
    logic [WBL_NUM_ST-1:0] next_status;
    // Levels are registered so they change just after an edge
    always_comb begin
        next_event  = ev_req_i;
        next_status = st_req_i;
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            event_o  <= '0;
            status_o <= '0;
        end else begin
            event_o  <= next_event;
            status_o <= next_status;
        end
    end
endmodule : wbl_src_model

// ---- work_bit_logic_unit_test.sv ----
/*
 * Self-checking bench for the work bit logic unit: register reads are
 * queued with expected values and compared by a watcher process.
 * Assumes the unit answers every request with one wait state.
 */
`timescale 1ns/10ps
module work_bit_logic_unit_test
    import wbl_pkg::*;
;
    // ====================================
    // Signals
    // ====================================
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wait_r;
    logic [5:0]  ev_req = 6'h00;
    logic [23:0] st_req = 24'h0;
    logic [5:0]  ev;
    logic [23:0] st;
    logic [31:0] exp_q[$];
    logic [15:0] seed = 16'h07fc;
    logic        r;
    logic [7:0]  wb_out;
    logic        dot_out;
    logic [31:0] e_w;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    wbl_src_model src_u (.core_clk_i(clk), .rst_n_i(rst_n), .ev_req_i(ev_req), .st_req_i(st_req),
        .event_o(ev), .status_o(st));
    wbl_unit #(.SEC_CYCLES(10)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .event_in_i(ev), .status_in_i(st),
        .work_bit_o(wb_out), .adj_dot_o(dot_out));

    // ====================================
    // Tasks
    // ====================================
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic f(input int op, input logic a, input logic b, input logic c, input logic d);
        case (op)
            1: return (a & b) | (c & d);
            2: return (a | c) & (b | d);
            3: return a | b | c | d;
            default: return a & b & c & d;
        endcase
    endfunction : f
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Held until waitrequest is seen low, then released and one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
        addr  <= a;
        rd_en <= ~w;
        wr_en <= w;
        wdata <= dt;
        do @(posedge clk); while (wait_r !== 1'b0);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        bus(1'b1, a, dt);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic chk_out(input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk_out
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    // Watcher takes the oldest note as each read is answered; a status
    // read also holds the live outputs against the same note
    always @(posedge clk) begin
        if (rst_n && rd_en && wait_r === 1'b0) begin
            e_w = exp_q.pop_front();
            chk(e_w, rdata);
            if (addr == WBL_REG_STATUS) chk_out({e_w[16], e_w[7:0]}, {dot_out, wb_out});
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_fail++;
            close_out();
        end
    end

    // ====================================
    // Scenarios
    // ====================================
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0);
        rd(8'hf0, 32'h0);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, 32'h0);
        $display("reset test done");
        // patterns with random inputs and inversion
        wr(8'h04, 32'h2509_0403);
        rd(8'h04, 32'h2509_0403);
        for (int op = 1; op <= 4; op++) begin
            for (int k = 0; k < 10; k++) begin
                seed = lfsr(seed);
                wr(8'h00, {23'h0, seed[12], seed[11:8], 1'b0, 3'(op)});
                ev_req <= seed[5:0];
                st_req <= {3'h0, seed[3], 19'h0, seed[2]};
                cyc(3);
                r = f(op, seed[0] ^ seed[8], seed[1] ^ seed[9], seed[2] ^ seed[10], seed[3] ^ seed[11]) ^ seed[12];
                rd(8'h80, {15'h0, 1'b1, 7'h0, r, 7'h0, r});
            end
        end
        wr(8'h00, 32'h5);
        rd(8'h00, 32'h0);
        rd(8'h80, 32'h0);
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h2901_0101);
        rd(8'h80, 32'h0001_0000);
        wr(8'h04, 32'h0101_0101);
        rd(8'h80, 32'h0001_0101);
        $display("pattern test done");
        ev_req <= 6'h00;
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h3);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h270f_270f);
        wr(8'h08, 32'h0002_0003);
        cyc(40);
        ev_req <= 6'h01;
        cyc(15);
        rd(8'h80, 32'h0001_0100);
        cyc(20);
        rd(8'h80, 32'h0001_0101);
        ev_req <= 6'h00;
        cyc(5);
        rd(8'h80, 32'h0001_0001);
        cyc(20);
        rd(8'h80, 32'h0001_0000);
        ev_req <= 6'h01;
        cyc(5);
        ev_req <= 6'h00;
        cyc(40);
        rd(8'h80, 32'h0001_0000);
        wr(8'h00, 32'h203);
        wr(8'h08, 32'h2);
        ev_req <= 6'h01;
        cyc(500);
        rd(8'h80, 32'h0001_0100);
        cyc(800);
        rd(8'h80, 32'h0001_0101);
        $display("delay test done");
        // feedback between bits, all eight bits, mid-run reset
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h0101_0101);
        wr(8'h10, 32'h3);
        wr(8'h14, 32'h1d);
        cyc(3);
        rd(8'h80, 32'h0001_0303);
        for (int n = 0; n < 8; n++) begin
            wr(8'(n * 16 + 4), 32'h0101_0101);
            wr(8'(n * 16), 32'h3);
        end
        cyc(3);
        rd(8'h80, 32'h0001_ffff);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        rd(8'h80, 32'h0);
        $display("bits test done");
        close_out();
    end
endmodule : work_bit_logic_unit_test
